// *** rtl/swpps_core.sv ***
// swpps_core: write burst, precharge, power-down, deep power-down and clock suspend
// assumes: controller keeps its own timing (recovery, precharge period, refresh, init)
//
// Operation
// - first write word taken with WRITE edge, one more each following edge
// - after fixed burst ends, data pins stay undriven and input data ignored
// - full-page burst runs until stopped, wrapping to start column at page end
// - write with auto precharge closes the row when the burst completes
// - new WRITE any cycle truncates old burst; its data belongs to new burst
// - READ during write burst stops the burst; that edge's data ignored
// - burst stop drops its own data; last word is the one before it
// - precharge uses all-bank bit, else the two bank bits pick one bank
// - precharged bank is idle; ACTIVE needed before READ or WRITE to it
// - clock gate low with NOP and no access enters power-down, precharge or active
// - power-down exits on clock gate high with NOP or deselect
// - stop code with clock gate low and all banks idle enters deep power-down
// - clock gate low during burst suspends the next internal edge
// - suspended edge ignores command and data, burst counter holds
// - clock gate high again resumes internal clocking on the next edge
// - byte mask has zero latency on write data
// - WRITE decodes from strobes and needs an open row in the bank
// - after power-down exit at edge n a command is taken at edge n plus one
`timescale 1ns/1ps
module swpps_core (
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_in,
   input  wire logic                          ce_in,
   input  wire logic                          cke_in,
   input  wire logic                          cs_n_in,
   input  wire logic                          ras_n_in,
   input  wire logic                          cas_n_in,
   input  wire logic                          we_n_in,
   input  wire logic [swpps_pkg::COL_W-1:0]    col_addr_in,
   input  wire logic                          all_bank_select_bit_in,
   input  wire logic                          bank_sel_bit0_in,
   input  wire logic                          bank_sel_bit1_in,
   input  wire logic [swpps_pkg::DM_W-1:0]     dm_in,
   input  wire logic [swpps_pkg::DQ_W-1:0]     dq_in,
   input  wire logic [swpps_pkg::BLSEL_W-1:0]  bl_sel_in,
   input  wire logic [swpps_pkg::MADDR_W-1:0]  peek_addr_in,
   output logic      [swpps_pkg::DQ_W-1:0]     dq_out,
   output logic                               dq_oe_out,
   output logic      [swpps_pkg::DQ_W-1:0]     peek_data_out,
   output logic      [swpps_pkg::NBANK-1:0]    bank_open_out,
   output logic                               burst_out,
   output logic                               suspend_out,
   output logic                               power_down_out,
   output logic                               active_pd_out,
   output logic                               deep_pd_out
);
   import swpps_pkg::*;

   swpps_cmd_t        cmd;
   swpps_pwr_t        pwr_q;
   logic [BANK_W-1:0] bank_sel;
   logic              cmd_ok;
   logic              wr_go;
   logic              term;
   logic              cont;
   logic              ap_end;
   logic              mem_we;
   logic [MADDR_W-1:0] mem_waddr;
   logic [COL_W-1:0]  mask_w;
   logic              susp_q;
   logic              burst_q;
   logic              ap_q;
   logic              page_q;
   logic [BANK_W-1:0] bank_q;
   logic [COL_W-1:0]  col_q;
   logic [COL_W-1:0]  start_q;
   logic [COL_W-1:0]  mask_q;
   logic [COL_W-1:0]  cnt_q;
   logic [NBANK-1:0]  open_q;
   logic [NBANK-1:0]  open_d;

   // ****************************************************************
   // command decode
   // ****************************************************************
   assign cmd      = swpps_decode(cs_n_in, ras_n_in, cas_n_in, we_n_in);
   assign bank_sel = {bank_sel_bit1_in, bank_sel_bit0_in};
   assign mask_w   = swpps_bl_mask(bl_sel_in);
   assign cmd_ok   = (pwr_q == PS_RUN) && !susp_q;
   assign wr_go    = cmd_ok && (cmd == CMD_WR) && open_q[bank_sel];

   // burst ends: READ, stop, precharge of its bank or all, or a new WRITE
   assign term = burst_q && cmd_ok && ((cmd == CMD_RD) || (cmd == CMD_STOP) ||
                 ((cmd == CMD_PRE) && (all_bank_select_bit_in || (bank_sel == bank_q))) ||
                 wr_go);
   assign cont   = burst_q && cmd_ok && !term;
   assign ap_end = ap_q && (term || (cont && !page_q && (cnt_q == COL_ONE)));

   // ****************************************************************
   // power state
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         pwr_q <= PS_RUN;
      end else if (ce_in) begin
         case (pwr_q)
            PS_RUN: begin
               if (!cke_in && !susp_q && !burst_q) begin
                  if (cmd == CMD_NOP) begin
                     pwr_q <= PS_PD;
                  end else if ((cmd == CMD_STOP) && (open_q == OPEN_RST)) begin
                     pwr_q <= PS_DPD;
                  end
               end
            end
            PS_PD: begin
               if (cke_in && (cmd == CMD_NOP)) begin
                  pwr_q <= PS_RUN;
               end
            end
            PS_DPD: begin
               if (cke_in) begin
                  pwr_q <= PS_RUN;
               end
            end
            default: pwr_q <= PS_RUN;
         endcase
      end
   end

   // ****************************************************************
   // clock suspend
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         susp_q <= 1'b0;
      end else if (ce_in) begin
         if (cke_in) begin
            susp_q <= 1'b0;
         end else if ((pwr_q == PS_RUN) && ((burst_q && !term) || wr_go)) begin
            susp_q <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // write burst sequencer
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         burst_q <= 1'b0;
         ap_q    <= 1'b0;
         page_q  <= 1'b0;
         bank_q  <= '0;
         col_q   <= '0;
         start_q <= '0;
         mask_q  <= '0;
         cnt_q   <= '0;
      end else if (ce_in) begin
         if (wr_go) begin
            burst_q <= (mask_w != 9'h000);
            ap_q    <= all_bank_select_bit_in && (mask_w != 9'h000);
            page_q  <= (bl_sel_in == BL_PAGE);
            bank_q  <= bank_sel;
            start_q <= col_addr_in;
            mask_q  <= mask_w;
            cnt_q   <= mask_w;
            col_q   <= swpps_next_col(col_addr_in, mask_w, bl_sel_in == BL_PAGE, col_addr_in);
         end else if (term) begin
            burst_q <= 1'b0;
            ap_q    <= 1'b0;
         end else if (cont) begin
            col_q <= swpps_next_col(col_q, mask_q, page_q, start_q);
            if (!page_q) begin
               cnt_q <= cnt_q - COL_ONE;
               if (cnt_q == COL_ONE) begin
                  burst_q <= 1'b0;
                  ap_q    <= 1'b0;
               end
            end
         end
      end
   end

   // ****************************************************************
   // bank open/idle tracking
   // ****************************************************************
   always_comb begin
      open_d = open_q;
      if (ap_end) begin
         open_d[bank_q] = 1'b0;
      end
      if (cmd_ok) begin
         if (cmd == CMD_ACT) begin
            open_d[bank_sel] = 1'b1;
         end else if (cmd == CMD_PRE) begin
            if (all_bank_select_bit_in) begin
               open_d = OPEN_RST;
            end else begin
               open_d[bank_sel] = 1'b0;
            end
         end
         if (wr_go && all_bank_select_bit_in && (mask_w == 9'h000)) begin
            open_d[bank_sel] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         open_q <= OPEN_RST;
      end else if (ce_in) begin
         open_q <= open_d;
      end
   end

   // ****************************************************************
   // array write path
   // ****************************************************************
   assign mem_we    = wr_go || cont;
   assign mem_waddr = wr_go ? {bank_sel, col_addr_in} : {bank_q, col_q};

   swpps_mem u_mem (
      .clk_sys_in (clk_sys_in),
      .ce_in      (ce_in),
      .we_in      (mem_we),
      .waddr_in   (mem_waddr),
      .wdata_in   (dq_in),
      .wbe_in     (~dm_in),
      .raddr_in   (peek_addr_in),
      .rdata_out  (peek_data_out)
   );

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign dq_out         = DQ_IDLE;
   assign dq_oe_out      = 1'b0;
   assign bank_open_out  = open_q;
   assign burst_out      = burst_q;
   assign suspend_out    = susp_q;
   assign power_down_out = (pwr_q == PS_PD);
   assign active_pd_out  = (pwr_q == PS_PD) && (open_q != OPEN_RST);
   assign deep_pd_out    = (pwr_q == PS_DPD);

endmodule // swpps_core

// *** rtl/swpps_pkg.sv ***
// swpps_pkg: widths, encodings and helper functions of the write/precharge/power block
// assumes: single system clock, command pins sampled on its rising edge
package swpps_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int unsigned COL_W   = 9;
   localparam int unsigned BANK_W  = 2;
   localparam int unsigned NBANK   = 4;
   localparam int unsigned DQ_W    = 16;
   localparam int unsigned DM_W    = 2;
   localparam int unsigned MADDR_W = BANK_W + COL_W;
   localparam int unsigned MDEPTH  = NBANK * (1 << COL_W);
   localparam int unsigned BLSEL_W = 3;

   // ****************************************************************
   // encodings and reset values
   // ****************************************************************
   localparam logic [COL_W-1:0]   COL_LAST  = 9'h1FF;
   localparam logic [COL_W-1:0]   COL_ONE   = 9'h001;
   localparam logic [BLSEL_W-1:0] BL_1      = 3'h0;
   localparam logic [BLSEL_W-1:0] BL_2      = 3'h1;
   localparam logic [BLSEL_W-1:0] BL_4      = 3'h2;
   localparam logic [BLSEL_W-1:0] BL_8      = 3'h3;
   localparam logic [BLSEL_W-1:0] BL_PAGE   = 3'h7;
   localparam logic [NBANK-1:0]   OPEN_RST  = 4'h0;
   localparam logic [DQ_W-1:0]    DQ_IDLE   = 16'h0000;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_STOP, CMD_OTHER
   } swpps_cmd_t;

   typedef enum logic [1:0] {
      PS_RUN, PS_PD, PS_DPD
   } swpps_pwr_t;

   // ****************************************************************
   // functions
   // ****************************************************************
   function automatic swpps_cmd_t swpps_decode(input logic cs_n, input logic ras_n,
                                               input logic cas_n, input logic we_n);
      swpps_cmd_t c;
      c = CMD_OTHER;
      if (cs_n) begin
         c = CMD_NOP;
      end else begin
         case ({ras_n, cas_n, we_n})
            3'h7:    c = CMD_NOP;
            3'h3:    c = CMD_ACT;
            3'h5:    c = CMD_RD;
            3'h4:    c = CMD_WR;
            3'h2:    c = CMD_PRE;
            3'h6:    c = CMD_STOP;
            default: c = CMD_OTHER;
         endcase
      end
      return c;
   endfunction

   // burst wrap mask; all ones means full page
   function automatic logic [COL_W-1:0] swpps_bl_mask(input logic [BLSEL_W-1:0] sel);
      logic [COL_W-1:0] m;
      m = 9'h000;
      case (sel)
         BL_1:    m = 9'h000;
         BL_2:    m = 9'h001;
         BL_4:    m = 9'h003;
         BL_8:    m = 9'h007;
         BL_PAGE: m = COL_LAST;
         default: m = 9'h000;
      endcase
      return m;
   endfunction

   // next column: wrap inside the burst block, or back to start at page end
   function automatic logic [COL_W-1:0] swpps_next_col(input logic [COL_W-1:0] col,
                                                       input logic [COL_W-1:0] mask,
                                                       input logic             page,
                                                       input logic [COL_W-1:0] start);
      logic [COL_W-1:0] n;
      n = col + COL_ONE;
      if (page) begin
         if (col == COL_LAST) begin
            n = start;
         end
      end else begin
         n = (col & ~mask) | (n & mask);
      end
      return n;
   endfunction

endpackage : swpps_pkg

// *** rtl/swpps_mem.sv ***
// swpps_mem: bank/column word store with byte enables, registered read port
// assumes: one clock, enable freezes writes and the read register
`timescale 1ns/1ps
module swpps_mem (
   input  wire logic                         clk_sys_in,
   input  wire logic                         ce_in,
   input  wire logic                         we_in,
   input  wire logic [swpps_pkg::MADDR_W-1:0] waddr_in,
   input  wire logic [swpps_pkg::DQ_W-1:0]    wdata_in,
   input  wire logic [swpps_pkg::DM_W-1:0]    wbe_in,
   input  wire logic [swpps_pkg::MADDR_W-1:0] raddr_in,
   output logic      [swpps_pkg::DQ_W-1:0]    rdata_out
);
   import swpps_pkg::*;

   logic [DQ_W-1:0] mem_q [MDEPTH];

   // ****************************************************************
   // byte-lane write, registered read
   // ****************************************************************
   always_ff @(posedge clk_sys_in) begin
      if (ce_in && we_in) begin
         if (wbe_in[0]) begin
            mem_q[waddr_in][7:0] <= wdata_in[7:0];
         end
         if (wbe_in[1]) begin
            mem_q[waddr_in][15:8] <= wdata_in[15:8];
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (ce_in) begin
         rdata_out <= mem_q[raddr_in];
      end
   end

endmodule // swpps_mem

// *** sim/swpps_core_props.sv ***
// swpps_core_props: port assertions for swpps_core
// assumes: bound into swpps_core, one clock, rst_in synchronous active high
`timescale 1ns/1ps
module swpps_core_props (
   input wire logic                          clk_sys_in,
   input wire logic                          rst_in,
   input wire logic                          ce_in,
   input wire logic                          cke_in,
   input wire logic                          cs_n_in,
   input wire logic                          ras_n_in,
   input wire logic                          cas_n_in,
   input wire logic                          we_n_in,
   input wire logic                          all_bank_select_bit_in,
   input wire logic                          bank_sel_bit0_in,
   input wire logic                          bank_sel_bit1_in,
   input wire logic                          dq_oe_out,
   input wire logic [swpps_pkg::NBANK-1:0]   bank_open_out,
   input wire logic                          burst_out,
   input wire logic                          suspend_out,
   input wire logic                          power_down_out,
   input wire logic                          active_pd_out,
   input wire logic                          deep_pd_out
);
   import swpps_pkg::*;
   // ************
   // decode and checks
   // ************
   logic [3:0] c;
   logic [1:0] bk;
   logic       acc;
   logic       nop;
   assign c   = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
   assign bk  = {bank_sel_bit1_in, bank_sel_bit0_in};
   assign acc = ce_in & ~power_down_out & ~deep_pd_out & ~suspend_out;
   assign nop = cs_n_in | (c[2:0] == 3'h7);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   hiz_hold_a: assert property (!dq_oe_out)
      else $error("data pins driven by device");
   pre_all_a: assert property (acc && c == 4'h2 && all_bank_select_bit_in
      |=> bank_open_out == 4'h0) else $error("all-bank precharge left a bank open");
   pre_one_a: assert property (acc && c == 4'h2 && !all_bank_select_bit_in
      |=> !bank_open_out[$past(bk)]) else $error("bank precharge left bank open");
   wr_idle_a: assert property (acc && c == 4'h4 && !bank_open_out[bk] && !burst_out
      |=> !burst_out) else $error("write to idle bank started a burst");
   stop_end_a: assert property (acc && cke_in && c == 4'h6 |=> !burst_out)
      else $error("burst stop did not end burst");
   read_end_a: assert property (acc && c == 4'h5 |=> !burst_out)
      else $error("read did not end write burst");
   pd_entry_a: assert property (ce_in && !cke_in && nop && !power_down_out && !deep_pd_out
      && !burst_out && !suspend_out |=> power_down_out && active_pd_out == |$past(bank_open_out))
      else $error("power-down entry wrong");
   susp_entry_a: assert property (ce_in && burst_out && !cke_in && nop && !suspend_out
      |=> suspend_out) else $error("clock suspend not entered");
   susp_exit_a: assert property (ce_in && suspend_out && cke_in |=> !suspend_out)
      else $error("clock suspend not left");
   susp_frz_a: assert property (suspend_out
      |=> $stable(bank_open_out) && $stable(burst_out)) else $error("state moved in suspend");
   deep_entry_a: assert property (ce_in && !cke_in && c == 4'h6 && bank_open_out == 4'h0
      && !power_down_out && !deep_pd_out && !burst_out && !suspend_out |=> deep_pd_out)
      else $error("deep power-down not entered");
endmodule // swpps_core_props
bind swpps_core swpps_core_props swpps_core_props_inst (.clk_sys_in, .rst_in, .ce_in, .cke_in,
   .cs_n_in, .ras_n_in, .cas_n_in, .we_n_in, .all_bank_select_bit_in, .bank_sel_bit0_in,
   .bank_sel_bit1_in, .dq_oe_out, .bank_open_out, .burst_out, .suspend_out, .power_down_out,
   .active_pd_out, .deep_pd_out);

// *** sim/swpps_ctrl_model.sv ***
// swpps_ctrl_model: controller side, drives command, mask, data and clock gate
// assumes: caller spaces commands for recovery, precharge period and refresh
`timescale 1ns/1ps
module swpps_ctrl_model (
   input  wire logic                       clk_sys_in,
   output logic                            cke_out,
   output logic                            cs_n_out,
   output logic                            ras_n_out,
   output logic                            cas_n_out,
   output logic                            we_n_out,
   output logic [swpps_pkg::COL_W-1:0]     col_out,
   output logic                            all_bank_select_bit_out,
   output logic                            bank_sel_bit0_out,
   output logic                            bank_sel_bit1_out,
   output logic [swpps_pkg::DM_W-1:0]      dm_out,
   output logic [swpps_pkg::DQ_W-1:0]      dq_out
);
   import swpps_pkg::*;
   // ************
   // command driver
   // ************
   initial begin
      cke_out = 1'b1;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
      {all_bank_select_bit_out, bank_sel_bit1_out, bank_sel_bit0_out} = 3'h0;
      col_out = 9'h000;
      dm_out = 2'h3;
      dq_out = 16'h0000;
   end
   // one command per edge; data with both bytes masked is the inverse of the last word
   task automatic send(input logic [3:0] c, input logic [2:0] ab_b, input logic [8:0] col,
                       input logic ke, input logic [1:0] m, input logic [15:0] d);
      @(posedge clk_sys_in);
      cke_out <= ke;
      {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= c;
      {all_bank_select_bit_out, bank_sel_bit1_out, bank_sel_bit0_out} <= ab_b;
      col_out <= col;
      dm_out <= m;
      dq_out <= (m == 2'h3) ? ~dq_out : d;
   endtask
   // idle cycles for recovery, precharge period and exit waits
   task automatic gap(input int n, input logic ke);
      repeat (n) send(4'hF, 3'h0, 9'h000, ke, 2'h3, 16'h0000);
   endtask
endmodule // swpps_ctrl_model

// *** sim/swpps_core_tb.sv ***
// swpps_core_tb: directed bench for swpps_core
// assumes: controller model drives the command side, peek port reads the array
`timescale 1ns/1ps
module swpps_core_tb;
   import swpps_pkg::*;
   // ************
   // bench
   // ************
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [2:0]  bl = 3'h0;
   logic [10:0] pk = 11'h000;
   int          n_fail = 0;
   int          total_checks = 0;
   wire         cke, cs_n, ras_n, cas_n, we_n, ab, b0, b1;
   wire [8:0]   col;
   wire [1:0]   dm;
   wire [15:0]  dq;
   logic [15:0] pdat, qo;
   logic [3:0]  bo;
   logic        bu, su, pd, apd, dpd, qoe;
   always #2.5 clk_sys_in = ~clk_sys_in;
   swpps_ctrl_model swpps_ctrl_model_inst (.clk_sys_in(clk_sys_in), .cke_out(cke),
      .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .col_out(col),
      .all_bank_select_bit_out(ab), .bank_sel_bit0_out(b0), .bank_sel_bit1_out(b1),
      .dm_out(dm), .dq_out(dq));
   swpps_core swpps_core_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1),
      .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
      .col_addr_in(col), .all_bank_select_bit_in(ab), .bank_sel_bit0_in(b0),
      .bank_sel_bit1_in(b1), .dm_in(dm), .dq_in(dq), .bl_sel_in(bl), .peek_addr_in(pk),
      .dq_out(qo), .dq_oe_out(qoe), .peek_data_out(pdat), .bank_open_out(bo), .burst_out(bu),
      .suspend_out(su), .power_down_out(pd), .active_pd_out(apd), .deep_pd_out(dpd));
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cm(input logic [3:0] c, input logic [2:0] ab_b, input logic ke,
                     input logic [15:0] d);
      swpps_ctrl_model_inst.send(c, ab_b, 9'h000, ke, 2'h0, d);
   endtask
   task automatic w(input logic [2:0] ab_b, input logic [8:0] ca, input logic [2:0] blv,
                    input logic [15:0] d);
      swpps_ctrl_model_inst.send(4'h4, ab_b, ca, 1'b1, 2'h0, d);
      bl <= blv;
   endtask
   task automatic dw(input logic [15:0] d, input logic [1:0] m, input logic ke);
      swpps_ctrl_model_inst.send(4'hF, 3'h0, 9'h000, ke, m, d);
   endtask
   task automatic nx(input logic ke);
      swpps_ctrl_model_inst.gap(1, ke);
      #1;
   endtask
   task automatic pchk(input logic [10:0] a, input logic [15:0] e);
      @(posedge clk_sys_in);
      pk <= a;
      @(posedge clk_sys_in);
      #1;
      chk("peek", pdat, e);
   endtask
   task automatic t_page;
      int j;
      cm(4'h3, 3'h3, 1'b1, 16'h0000);
      w(3'h3, 9'h1F4, 3'h7, 16'h1000);
      for (j = 1; j < 20; j++) begin
         dw(16'h1000 + 16'(j), 2'h0, 1'b1);
      end
      cm(4'h6, 3'h3, 1'b1, 16'hBEEF);
      nx(1'b1);
      chk("burst", {15'h0000, bu}, 16'h0000);
      chk("dq", qo, DQ_IDLE);
      chk("dq_oe", {15'h0000, qoe}, 16'h0000);
      for (j = 0; j < 12; j++) begin
         pchk(11'h7F4 + 11'(j), 16'h1000 + 16'((j < 8) ? j + 12 : j));
      end
      $display("t_page done");
   endtask
   task automatic t_trunc;
      w(3'h3, 9'h1F8, 3'h3, 16'h2000);
      dw(16'h2001, 2'h0, 1'b1);
      w(3'h3, 9'h1F4, 3'h3, 16'h3000);
      dw(16'h3001, 2'h1, 1'b1);
      cm(4'h5, 3'h3, 1'b1, 16'h4000);
      nx(1'b1);
      chk("burst", {15'h0000, bu}, 16'h0000);
      pchk(11'h7F8, 16'h2000);
      pchk(11'h7F9, 16'h2001);
      pchk(11'h7FA, 16'h1012);
      pchk(11'h7F4, 16'h3000);
      pchk(11'h7F5, 16'h300D);
      pchk(11'h7F6, 16'h100E);
      $display("t_trunc done");
   endtask
   task automatic t_pre;
      cm(4'h3, 3'h0, 1'b1, 16'h0000);
      cm(4'h3, 3'h2, 1'b1, 16'h0000);
      w(3'h2, 9'h000, 3'h3, 16'h5A5A);
      swpps_ctrl_model_inst.gap(2, 1'b1);
      swpps_ctrl_model_inst.send(4'h2, 3'h2, 9'h000, 1'b1, 2'h3, 16'h0000);
      nx(1'b1);
      chk("open", {12'h000, bo}, 16'h0009);
      chk("burst", {15'h0000, bu}, 16'h0000);
      swpps_ctrl_model_inst.gap(2, 1'b1);
      w(3'h2, 9'h000, 3'h1, 16'h0F0F);
      nx(1'b1);
      pchk(11'h400, 16'h5A5A);
      w(3'h4, 9'h008, 3'h1, 16'h7000);
      dw(16'h7001, 2'h0, 1'b1);
      nx(1'b1);
      chk("open", {12'h000, bo}, 16'h0008);
      pchk(11'h009, 16'h7001);
      $display("t_pre done");
   endtask
   task automatic t_susp;
      w(3'h3, 9'h010, 3'h2, 16'h6000);
      dw(16'h6001, 2'h0, 1'b0);
      dw(16'h6FFF, 2'h0, 1'b1);
      #1;
      chk("susp", {15'h0000, su}, 16'h0001);
      dw(16'h6002, 2'h0, 1'b1);
      #1;
      chk("susp", {15'h0000, su}, 16'h0000);
      dw(16'h6003, 2'h0, 1'b1);
      nx(1'b1);
      pchk(11'h611, 16'h6001);
      pchk(11'h612, 16'h6002);
      pchk(11'h613, 16'h6003);
      $display("t_susp done");
   endtask
   task automatic t_power;
      swpps_ctrl_model_inst.gap(1, 1'b0);
      nx(1'b0);
      chk("pd", {14'h0000, pd, apd}, 16'h0003);
      cm(4'h2, 3'h4, 1'b0, 16'h0000);
      nx(1'b0);
      chk("open", {12'h000, bo}, 16'h0008);
      swpps_ctrl_model_inst.gap(1, 1'b1);
      cm(4'h2, 3'h5, 1'b1, 16'h0000);
      nx(1'b1);
      chk("open", {11'h000, pd, bo}, 16'h0000);
      swpps_ctrl_model_inst.gap(1, 1'b0);
      nx(1'b0);
      chk("pd", {14'h0000, pd, apd}, 16'h0002);
      swpps_ctrl_model_inst.gap(1, 1'b1);
      nx(1'b1);
      chk("pd", {15'h0000, pd}, 16'h0000);
      cm(4'h6, 3'h0, 1'b0, 16'h0000);
      nx(1'b0);
      chk("deep", {15'h0000, dpd}, 16'h0001);
      swpps_ctrl_model_inst.gap(3, 1'b0);
      swpps_ctrl_model_inst.gap(1, 1'b1);
      nx(1'b1);
      chk("deep", {15'h0000, dpd}, 16'h0000);
      swpps_ctrl_model_inst.gap(8, 1'b1);
      $display("t_power done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      t_page();
      t_trunc();
      t_pre();
      t_susp();
      t_power();
      summarize();
   end
endmodule // swpps_core_tb
